// file: logic/cdc_pkg.sv
// cdc_pkg: shared constants and types of the cable driver control link
package cdc_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SCL_PERIOD_NS = 10000;
	localparam int unsigned QUARTER_CYC   =
		(SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POR_MS        = 500;
	localparam int unsigned POR_CYC       = POR_MS * 1000000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// device registers
	// ----------------------------------------------------------------
	localparam logic [6:0] DEF_DEV_ADDR   = 7'h17;
	localparam logic [7:0] REG_DEV_ADDR   = 8'h00;
	localparam logic [7:0] REG_CTRL       = 8'h01;
	localparam logic [7:0] REG_STATUS     = 8'h02;
	localparam int         CTRL_SLEW      = 0;
	localparam int         CTRL_MASK_LOSS = 1;
	localparam int         CTRL_MASK_TERM = 2;
	localparam logic [2:0] CTRL_RESET     = 3'h0;

	// ----------------------------------------------------------------
	// device pin synchroniser lanes
	// ----------------------------------------------------------------
	localparam int         SYNC_W  = 7;
	localparam int         SI_SCL  = 0;
	localparam int         SI_SDA  = 1;
	localparam int         SI_RST  = 2;
	localparam int         SI_EN   = 3;
	localparam int         SI_SLEW = 4;
	localparam int         SI_LOSS = 5;
	localparam int         SI_TERM = 6;
	// pulled pins rest at their pull level: reset-in high, enable high, slew low
	localparam logic [6:0] SYNC_RESET = 7'h2f;

	// ----------------------------------------------------------------
	// host command registers (AHB-Lite byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] HOST_CMD    = 8'h00;
	localparam logic [7:0] HOST_TARGET = 8'h04;
	localparam logic [7:0] HOST_STATUS = 8'h08;
	localparam logic [7:0] HOST_GPO    = 8'h0c;
	localparam int         CMD_GO      = 0;
	localparam int         CMD_READ    = 1;

	typedef enum logic [2:0] {
		DS_IDLE, DS_ADDR, DS_REG, DS_DATA, DS_ACK, DS_READ, DS_RACK
	} cdc_dev_state_t;

	typedef enum logic [2:0] {
		HS_POR, HS_IDLE, HS_START, HS_BIT, HS_STOP
	} cdc_host_state_t;
endpackage

// file: logic/cdc_smbus_if.sv
// cdc_smbus_if: management bus, chain reset and fault wires between host and device
`timescale 1ns/1ps
interface cdc_smbus_if;
	logic scl;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic sda;
	logic chain_reset_n;
	logic fault_oe;
	logic fault_n;

	// open-drain wires with external pull-ups
	assign sda     = ~(sda_host_oe | sda_dev_oe);
	assign fault_n = ~fault_oe;

	modport dev (
		input  scl, sda, chain_reset_n,
		output sda_dev_oe, fault_oe
	);
	modport host (
		input  sda, fault_n,
		output scl, sda_host_oe, chain_reset_n
	);
endinterface

// file: logic/cdc_sync3.sv
// cdc_sync3: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cdc_sync3 #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         ce,
	// pins
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ff1  <= RST;
			ff2  <= RST;
			ff3  <= RST;
			dout <= RST;
		end else if (ce) begin
			ff1 <= din;
			ff2 <= ff1;
			ff3 <= ff2;
			// a lane moves only once stages two and three agree
			for (int i = 0; i < W; i++) begin
				if (ff2[i] == ff3[i]) begin
					dout[i] <= ff3[i];
				end
			end
		end
	end
endmodule

// file: logic/cdc_host.sv
// cdc_host: management bus host with chain reset output, driven over AHB-Lite
`timescale 1ns/1ps
module cdc_host
	import cdc_pkg::*;
#(
	parameter int unsigned POR_WAIT = POR_CYC
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// link
	cdc_smbus_if.host        bus
);
	cdc_host_state_t hstate;
	logic [1:0]  syn;
	logic        a_act;
	logic        a_wr;
	logic [7:0]  a_addr;
	logic        go_pulse;
	logic        go_read;
	logic [6:0]  tgt_addr;
	logic [7:0]  tgt_reg;
	logic [7:0]  tgt_data;
	logic        is_read;
	logic        nack;
	logic [7:0]  rdata;
	logic [31:0] por_cnt;
	logic [8:0]  qcnt;
	logic [2:0]  q;
	logic [2:0]  seq;
	logic [3:0]  bitn;
	logic [7:0]  txb;
	logic [7:0]  rxb;
	logic [2:0]  seq_n;
	logic [31:0] rd_mux;

	cdc_sync3 #(.W(2), .RST(2'h3)) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.din     ({bus.fault_n, bus.sda}),
		.dout    (syn)
	);

	// ----------------------------------------------------------------
	// transfer steps: write is 3 bytes then stop, read adds restart
	// ----------------------------------------------------------------
	function automatic cdc_host_state_t step_state(input logic rd, input logic [2:0] s);
		if (rd) begin
			case (s)
				3'h0, 3'h1, 3'h3, 3'h4: return HS_BIT;
				3'h2:                   return HS_START;
				default:                return HS_STOP;
			endcase
		end
		return (s < 3'h3) ? HS_BIT : HS_STOP;
	endfunction

	function automatic logic [7:0] step_byte(input logic [2:0] s);
		case (s)
			3'h0:    return {tgt_addr, 1'b0};
			3'h1:    return tgt_reg;
			3'h2:    return tgt_data;
			3'h3:    return {tgt_addr, 1'b1};
			default: return 8'hff; // released line, ends with a nack
		endcase
	endfunction

	assign seq_n = seq + 3'h1;

	always_comb begin
		rd_mux = 32'h0;
		case (a_addr)
			HOST_CMD:    rd_mux = {31'h0, is_read};
			HOST_TARGET: rd_mux = {8'h0, tgt_data, tgt_reg, 1'b0, tgt_addr};
			HOST_STATUS: rd_mux = {16'h0, rdata, 4'h0, ~syn[1],
				hstate != HS_POR, nack, hstate != HS_IDLE};
			HOST_GPO:    rd_mux = {31'h0, bus.chain_reset_n};
			default:     rd_mux = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// ahb-lite slave, one wait state on reads, always okay
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_act             <= 1'b0;
			a_wr              <= 1'b0;
			a_addr            <= 8'h0;
			hrdata            <= 32'h0;
			hreadyout         <= 1'b1;
			hresp             <= 1'b0;
			go_pulse          <= 1'b0;
			go_read           <= 1'b0;
			tgt_addr          <= DEF_DEV_ADDR;
			tgt_reg           <= 8'h0;
			tgt_data          <= 8'h0;
			bus.chain_reset_n <= 1'b0;
		end else if (ce) begin
			a_act    <= hsel & htrans[1] & hready;
			// a read waits one cycle so hrdata is a flop and still valid when sampled
			hreadyout <= ~(hsel & htrans[1] & hready & ~hwrite);
			a_wr     <= hwrite;
			a_addr   <= {haddr[7:2], 2'b00};
			go_pulse <= 1'b0;
			if (a_act && !a_wr) begin
				hrdata <= rd_mux;
			end
			if (a_act && a_wr) begin
				case (a_addr)
					HOST_CMD: begin
						// a go while busy is dropped
						go_pulse <= hwdata[CMD_GO] & (hstate == HS_IDLE);
						go_read  <= hwdata[CMD_READ];
					end
					HOST_TARGET: begin
						tgt_addr <= hwdata[6:0];
						tgt_reg  <= hwdata[15:8];
						tgt_data <= hwdata[23:16];
					end
					HOST_GPO: bus.chain_reset_n <= hwdata[0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// bit engine, four quarters per bit, six per start or stop
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hstate          <= HS_POR;
			por_cnt         <= 32'h0;
			qcnt            <= 9'h0;
			q               <= 3'h0;
			seq             <= 3'h0;
			bitn            <= 4'h0;
			txb             <= 8'h0;
			rxb             <= 8'h0;
			rdata           <= 8'h0;
			nack            <= 1'b0;
			is_read         <= 1'b0;
			bus.scl         <= 1'b1;
			bus.sda_host_oe <= 1'b0;
		end else if (ce) begin
			case (hstate)
				HS_POR: begin
					// no traffic until the device is surely up
					if (por_cnt >= POR_WAIT - 1) begin
						hstate <= HS_IDLE;
					end else begin
						por_cnt <= por_cnt + 32'h1;
					end
				end
				HS_IDLE: begin
					if (go_pulse) begin
						is_read <= go_read;
						nack    <= 1'b0;
						seq     <= 3'h7;
						q       <= 3'h0;
						qcnt    <= 9'h0;
						hstate  <= HS_START;
					end
				end
				default: begin
					// quarter of a 10 us period keeps scl within 10..100 kHz
					if (qcnt == 9'(QUARTER_CYC - 1)) begin
						qcnt <= 9'h0;
						q    <= q + 3'h1;
						if (hstate == HS_BIT) begin
							case (q)
								3'h0: bus.scl <= 1'b0;
								3'h1: bus.sda_host_oe <= (bitn < 4'h8) ? ~txb[7] : 1'b0;
								3'h2: bus.scl <= 1'b1;
								default: begin
									q <= 3'h0;
									if (bitn < 4'h8) begin
										txb  <= {txb[6:0], 1'b0};
										rxb  <= {rxb[6:0], syn[0]};
										bitn <= bitn + 4'h1;
									end else if (syn[0] && !(is_read && seq == 3'h4)) begin
										nack   <= 1'b1;
										hstate <= HS_STOP;
									end else begin
										if (is_read && seq == 3'h4) begin
											rdata <= rxb;
										end
										seq    <= seq_n;
										bitn   <= 4'h0;
										txb    <= step_byte(seq_n);
										hstate <= step_state(is_read, seq_n);
									end
								end
							endcase
						end else begin
							// start: sda falls after 2 quarters high, held 2 more
							case (q)
								3'h0: bus.scl <= 1'b0;
								3'h1: bus.sda_host_oe <= (hstate == HS_STOP);
								3'h2: bus.scl <= 1'b1;
								3'h4: bus.sda_host_oe <= (hstate == HS_START);
								3'h5: begin
									q <= 3'h0;
									if (hstate == HS_STOP) begin
										// next start comes at least 6 quarters after sda rises
										hstate <= HS_IDLE;
									end else begin
										seq    <= seq_n;
										bitn   <= 4'h0;
										txb    <= step_byte(seq_n);
										hstate <= step_state(is_read, seq_n);
									end
								end
								default: ;
							endcase
						end
					end else begin
						qcnt <= qcnt + 9'h1;
					end
				end
			endcase
		end
	end
endmodule

// file: logic/cdc_device.sv
// cdc_device: control, status and management bus slave of the cable driver
// ----------------------------------------------------------------
// Functional notes
// - chain reset low holds registers at defaults
// - open chain reset input counts as high
// - writing register 0 raises chain reset output
// - chain reset input low forces output low
// - each chain output feeds next device's input
// - enable high drives output, low powers off
// - slew high selects slow edges, default fast
// - fault flag low on signal loss/termination fault
// - fault flag is open drain, pull low only
// - data line open drain, pull low only
// - host clock between 10 and 100 kHz
// - host leaves 4.7 us free after stop
// - host setup and clock-low times respected
// - operational within 500 ms of power-on
// - responds at default address after reset
// - register slew applies only while pin low
// - fault sources maskable and readable by software
// - write is address, register, data, each acked
// ----------------------------------------------------------------
`timescale 1ns/1ps
module cdc_device
	import cdc_pkg::*;
(
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	// control pins
	input  wire logic output_enable,
	input  wire logic slew_select,
	// detector inputs
	input  wire logic signal_loss_n,
	input  wire logic term_fault,
	// driver control and chain
	output logic      serial_out_enable,
	output logic      slew_sd,
	output logic      chain_reset_out_n,
	// link
	cdc_smbus_if.dev  bus
);
	cdc_dev_state_t state;
	cdc_dev_state_t ack_next;
	logic [SYNC_W-1:0] syn;
	logic              scl_q;
	logic              sda_q;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_seen;
	logic              stop_seen;
	logic              chain_rst;
	logic [2:0]        cnt;
	logic              byte_done;
	logic [7:0]        shreg;
	logic [7:0]        txreg;
	logic [7:0]        ptr;
	logic              host_acked;
	logic [6:0]        dev_addr;
	logic [2:0]        ctrl;
	logic              loss_active;
	logic              wr_commit;
	logic [7:0]        rd_data;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// the clock line is sampled only; there is no drive path for it
	cdc_sync3 #(.W(SYNC_W), .RST(SYNC_RESET)) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.din     ({term_fault, signal_loss_n, slew_select, output_enable,
			bus.chain_reset_n, bus.sda, bus.scl}),
		.dout    (syn)
	);

	// reset lane rests high, so a floating input runs normally
	assign chain_rst   = ~syn[SI_RST];
	assign loss_active = ~syn[SI_LOSS];

	// ----------------------------------------------------------------
	// line events
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_q <= syn[SI_SCL];
			sda_q <= syn[SI_SDA];
		end
	end

	assign scl_rise   = syn[SI_SCL] & ~scl_q;
	assign scl_fall   = ~syn[SI_SCL] & scl_q;
	// data moving while the clock stays high frames a message
	assign start_seen = syn[SI_SCL] & scl_q & sda_q & ~syn[SI_SDA];
	assign stop_seen  = syn[SI_SCL] & scl_q & ~sda_q & syn[SI_SDA];

	// data byte taken at the falling edge that opens its ack slot
	assign wr_commit = ~chain_rst & ~start_seen & ~stop_seen & scl_fall
		& (state == DS_DATA) & byte_done;

	always_comb begin
		rd_data = 8'h0;
		case (ptr)
			REG_DEV_ADDR: rd_data = {1'b0, dev_addr};
			REG_CTRL:     rd_data = {5'h0, ctrl};
			REG_STATUS:   rd_data = {4'h0, slew_sd, serial_out_enable,
				syn[SI_TERM], loss_active};
			default:      rd_data = 8'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// bus slave sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state          <= DS_IDLE;
			ack_next       <= DS_IDLE;
			cnt            <= 3'h0;
			byte_done      <= 1'b0;
			shreg          <= 8'h0;
			txreg          <= 8'h0;
			ptr            <= 8'h0;
			host_acked     <= 1'b0;
			bus.sda_dev_oe <= 1'b0;
		end else if (ce) begin
			if (chain_rst || stop_seen) begin
				// held in reset the slave stays deaf and releases the line
				state          <= DS_IDLE;
				byte_done      <= 1'b0;
				bus.sda_dev_oe <= 1'b0;
			end else if (start_seen) begin
				state          <= DS_ADDR;
				cnt            <= 3'h0;
				byte_done      <= 1'b0;
				bus.sda_dev_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					DS_ADDR, DS_REG, DS_DATA: begin
						shreg     <= {shreg[6:0], syn[SI_SDA]};
						cnt       <= cnt + 3'h1;
						byte_done <= (cnt == 3'h7);
					end
					DS_READ: begin
						cnt       <= cnt + 3'h1;
						byte_done <= (cnt == 3'h7);
					end
					DS_RACK: host_acked <= ~syn[SI_SDA];
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
					DS_ADDR: begin
						if (byte_done) begin
							byte_done <= 1'b0;
							// another address: sit out until the next start
							if (shreg[7:1] == dev_addr) begin
								bus.sda_dev_oe <= 1'b1;
								state          <= DS_ACK;
								ack_next       <= shreg[0] ? DS_READ : DS_REG;
							end else begin
								state <= DS_IDLE;
							end
						end
					end
					DS_REG: begin
						if (byte_done) begin
							byte_done      <= 1'b0;
							ptr            <= shreg;
							bus.sda_dev_oe <= 1'b1;
							state          <= DS_ACK;
							ack_next       <= DS_DATA;
						end
					end
					DS_DATA: begin
						if (byte_done) begin
							// further data bytes are not acked, host must stop
							byte_done      <= 1'b0;
							bus.sda_dev_oe <= 1'b1;
							state          <= DS_ACK;
							ack_next       <= DS_IDLE;
						end
					end
					DS_ACK: begin
						state <= ack_next;
						if (ack_next == DS_READ) begin
							txreg          <= rd_data;
							bus.sda_dev_oe <= ~rd_data[7];
						end else begin
							bus.sda_dev_oe <= 1'b0;
						end
					end
					DS_READ: begin
						if (byte_done) begin
							byte_done      <= 1'b0;
							bus.sda_dev_oe <= 1'b0;
							state          <= DS_RACK;
						end else begin
							// ones are sent by letting go, never by driving high
							txreg          <= {txreg[6:0], 1'b0};
							bus.sda_dev_oe <= ~txreg[6];
						end
					end
					DS_RACK: begin
						// an acked read repeats the same register
						if (host_acked) begin
							txreg          <= rd_data;
							bus.sda_dev_oe <= ~rd_data[7];
							state          <= DS_READ;
						end else begin
							state <= DS_IDLE;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers and chain reset
	// ----------------------------------------------------------------
	// ready a few cycles after reset; no start-up delay of its own
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_addr          <= DEF_DEV_ADDR;
			ctrl              <= CTRL_RESET;
			chain_reset_out_n <= 1'b0;
		end else if (ce) begin
			if (chain_rst) begin
				dev_addr          <= DEF_DEV_ADDR;
				ctrl              <= CTRL_RESET;
				chain_reset_out_n <= 1'b0;
			end else if (wr_commit) begin
				case (ptr)
					REG_DEV_ADDR: begin
						dev_addr          <= shreg[6:0];
						// releases the next device in the chain
						chain_reset_out_n <= 1'b1;
					end
					REG_CTRL: ctrl <= shreg[2:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// driver control and fault flag
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_out_enable <= 1'b1;
			slew_sd           <= 1'b0;
			bus.fault_oe      <= 1'b0;
		end else if (ce) begin
			serial_out_enable <= syn[SI_EN];
			// pin high forces slow edges; the register bit only acts while pin low
			slew_sd <= syn[SI_SLEW] | ctrl[CTRL_SLEW];
			// pull-only enable, line is wired-or with other drivers
			bus.fault_oe <= (loss_active & ~ctrl[CTRL_MASK_LOSS])
				| (syn[SI_TERM] & ~ctrl[CTRL_MASK_TERM]);
		end
	end
endmodule

// file: test/cdc_link_chk.sv
// cdc_link_chk: timing and open-drain checks on the management link
`timescale 1ns/1ps
module cdc_link_chk
	import cdc_pkg::*;
(
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// link wires
	input  wire logic scl,
	input  wire logic sda_host_oe,
	input  wire logic sda_dev_oe,
	input  wire logic sda,
	input  wire logic chain_reset_n,
	input  wire logic fault_oe,
	input  wire logic fault_n
);
	// ------
	// helper counters
	// ------
	logic [15:0] lo_len, hi_len, sda_hi, since_fall, since_st, ack_len;

	// saturate so a long idle bus never wraps into a short count
	function automatic logic [15:0] inc(input logic [15:0] v);
		return v + {15'h0, v != 16'hffff};
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_len     <= '0;
			hi_len     <= '1;
			sda_hi     <= '1;
			since_fall <= '1;
			since_st   <= '1;
			ack_len    <= '0;
		end else begin
			lo_len     <= scl ? '0 : inc(lo_len);
			hi_len     <= scl ? inc(hi_len) : '0;
			sda_hi     <= sda ? inc(sda_hi) : '0;
			since_fall <= $fell(scl) ? '0 : inc(since_fall);
			since_st   <= (scl && $fell(sda)) ? '0 : inc(since_st);
			ack_len    <= sda_dev_oe ? inc(ack_len) : '0;
		end
	end

	// ------
	// assertions
	// ------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_held_reset;
		!chain_reset_n [*8];
	endsequence

	a_sda_pull_low: assert property (sda_dev_oe |-> !sda)
		else $error("data line high while device pulls it");
	a_fault_pull_low: assert property (fault_oe |-> !fault_n)
		else $error("fault line high while device pulls it");
	a_quiet_in_reset: assert property (s_held_reset |-> !sda_dev_oe)
		else $error("device drives data line in chain reset");
	a_dev_after_fall: assert property ($changed(sda_dev_oe) |->
		!scl && since_fall >= 1 && since_fall <= 12)
		else $error("device data change not just after clock fall");
	a_ack_max: assert property (sda_dev_oe |-> ack_len <= 4 * QUARTER_CYC + 16)
		else $error("device ack held too long");
	a_ack_min: assert property ($fell(sda_dev_oe) |-> ack_len >= 4 * QUARTER_CYC - 16)
		else $error("device ack too short");
	a_clk_high_min: assert property ($fell(scl) |-> hi_len >= 500)
		else $error("clock high phase too short");
	a_clk_low_min: assert property ($rose(scl) |-> lo_len >= 588)
		else $error("clock low phase too short");
	a_clk_low_max: assert property (!scl |-> lo_len < 12500)
		else $error("clock low beyond slowest rate");
	a_bus_free: assert property (s_start |-> sda_hi >= 588)
		else $error("start too soon after data line rose");
	a_start_hold: assert property ($fell(scl) |-> since_st >= 500)
		else $error("first clock too soon after start");
endmodule

// file: test/cable_driver_ctrl_smbus_test.sv
// cable_driver_ctrl_smbus_test: host and device joined over the link, driven over ahb-lite
`timescale 1ns/1ps
module cable_driver_ctrl_smbus_test
	import cdc_pkg::*;
;
	logic        hclk, hresetn, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic        oe_pin, slew_pin, loss_n, term, drv_en, slew_sd, chain_out_n;
	int          err_total;
	int          tests_run;

	always #4 hclk = ~hclk;

	cdc_smbus_if cdc_smbus_if_inst ();
	cdc_host #(.POR_WAIT(20)) cdc_host_inst (
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .bus(cdc_smbus_if_inst.host)
	);
	cdc_device cdc_device_inst (
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .output_enable(oe_pin),
		.slew_select(slew_pin), .signal_loss_n(loss_n), .term_fault(term),
		.serial_out_enable(drv_en), .slew_sd(slew_sd), .chain_reset_out_n(chain_out_n),
		.bus(cdc_smbus_if_inst.dev)
	);
	cdc_link_chk cdc_link_chk_inst (
		.hclk(hclk), .hresetn(hresetn), .scl(cdc_smbus_if_inst.scl),
		.sda_host_oe(cdc_smbus_if_inst.sda_host_oe), .sda_dev_oe(cdc_smbus_if_inst.sda_dev_oe),
		.sda(cdc_smbus_if_inst.sda), .chain_reset_n(cdc_smbus_if_inst.chain_reset_n),
		.fault_oe(cdc_smbus_if_inst.fault_oe), .fault_n(cdc_smbus_if_inst.fault_n)
	);

	// ------
	// access tasks
	// ------
	// read data and response are taken at the edge that ends the data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, 32'(hresp));
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic txn(input logic [31:0] t, input logic [31:0] c);
		ahb(1'b1, HOST_TARGET, t);
		ahb(1'b1, HOST_CMD, c);
		ahb(1'b0, HOST_STATUS, 32'h0);
		chk("busy", 32'h1, 32'(rd[0]));
		while (rd[0] === 1'b1) ahb(1'b0, HOST_STATUS, 32'h0);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ------
	// tests
	// ------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = '0;
		oe_pin = 1'b1;
		slew_pin = 1'b0;
		loss_n = 1'b1;
		term = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		cyc(2);
		chk("chain_out", 32'h0, 32'(chain_out_n));
		chk("drv_en", 32'h1, 32'(drv_en));
		chk("slew", 32'h0, 32'(slew_sd));
		chk("fault", 32'h1, 32'(cdc_smbus_if_inst.fault_n));
		@(posedge hclk);
		oe_pin <= 1'b0;
		slew_pin <= 1'b1;
		loss_n <= 1'b0;
		cyc(8);
		chk("drv_en", 32'h0, 32'(drv_en));
		chk("slew", 32'h1, 32'(slew_sd));
		chk("fault", 32'h0, 32'(cdc_smbus_if_inst.fault_n));
		ahb(1'b0, HOST_STATUS, 32'h0);
		chk("fault_bit", 32'h1, 32'(rd[3]));
		@(posedge hclk);
		oe_pin <= 1'b1;
		slew_pin <= 1'b0;
		loss_n <= 1'b1;
		term <= 1'b1;
		cyc(8);
		chk("fault", 32'h0, 32'(cdc_smbus_if_inst.fault_n));
		chk("drv_en", 32'h1, 32'(drv_en));
		@(posedge hclk);
		term <= 1'b0;
		cyc(8);
		chk("fault", 32'h1, 32'(cdc_smbus_if_inst.fault_n));
		do ahb(1'b0, HOST_STATUS, 32'h0); while (rd[2] !== 1'b1);
		ahb(1'b1, HOST_GPO, 32'h1);
		cyc(8);
		// register 0 at the default address moves it to 16h
		txn(32'h0016_0017, 32'h1);
		chk("nack", 32'h0, 32'(rd[1]));
		chk("chain_out", 32'h1, 32'(chain_out_n));
		@(posedge hclk);
		loss_n <= 1'b0;
		term <= 1'b1;
		txn(32'h0007_0116, 32'h1);
		chk("nack", 32'h0, 32'(rd[1]));
		chk("slew", 32'h1, 32'(slew_sd));
		chk("fault", 32'h1, 32'(cdc_smbus_if_inst.fault_n));
		ahb(1'b1, HOST_GPO, 32'h0);
		cyc(8);
		chk("chain_out", 32'h0, 32'(chain_out_n));
		chk("slew", 32'h0, 32'(slew_sd));
		chk("fault", 32'h0, 32'(cdc_smbus_if_inst.fault_n));
		// a device held in chain reset stays deaf even at its default address
		txn(32'h0000_0017, 32'h3);
		chk("nack", 32'h1, 32'(rd[1]));
		ahb(1'b0, HOST_CMD, 32'h0);
		chk("read_flag", 32'h1, 32'(rd[0]));
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
		tally_and_finish();
	end

	// two full writes and one refused read take about 90k cycles
	initial begin
		#(98000 * 8);
		err_total++;
		tally_and_finish();
	end
endmodule
